// ---- common/mfcu_cfg.svh ----
// Purpose: constants of the frame check unit
// Assumes: included by bare name
// Notes: definitions only
`ifndef MFCU_CFG_SVH
`define MFCU_CFG_SVH

`define MFCU_CRC_PRESET 16'hffff
`define MFCU_CRC_POLY 16'ha001
`define MFCU_LAST_STEP 3'h7
`define MFCU_CHR_START 8'h3a
`define MFCU_CHR_CR 8'h0d
`define MFCU_CHR_LF 8'h0a
`define MFCU_FUNC_WMULTI 8'h10
`define MFCU_ADDR_BCAST 8'h00
`define MFCU_HDR_BYTES 6'h06
`define MFCU_MIN_ASCII 6'h03
`define MFCU_MIN_RTU 6'h04
`define MFCU_REQ_MIN_ASCII 6'h08
`define MFCU_REQ_MIN_RTU 6'h09
`define MFCU_NBYTES_MAX 6'h3f
`define MFCU_TX_LAST_ASCII 5'h10
`define MFCU_TX_LAST_RTU 5'h07
`define MFCU_FIFO_DEPTH 8

`endif

// ---- common/mfcu_pkg.sv ----
// Purpose: types of the frame check unit
// Assumes: nothing
// Notes: state enums only
`default_nettype none
package mfcu_pkg;
   typedef enum logic [1:0] {RX_COLLECT, RX_SHIFT, RX_EVAL, RX_WAIT} mfcu_rx_st_t;
   typedef enum logic {TX_IDLE, TX_SEND} mfcu_tx_st_t;
endpackage
`default_nettype wire

// ---- core/mfcu_fifo.sv ----
// Purpose: receive buffer between link and checker
// Assumes: single clock, out side may stall
// Notes: depth is a power of two
`default_nettype none
module mfcu_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // storage holds no reset; only valid words are ever read
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ---- core/mfcu_frame_check.sv ----
// Purpose: frame check and write-multiple reply for the serial slave link
// Assumes: characters or bytes arrive already deframed; mode stable per frame
// Notes: ascii mode takes characters, rtu mode takes bytes with a last flag
`include "mfcu_cfg.svh"
`default_nettype none
module mfcu_frame_check #(
   parameter int FIFO_DEPTH = `MFCU_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // framing mode
   input wire logic mode_ascii,
   // receive stream
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   // transmit stream
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   // frame status
   output logic frame_good,
   output logic frame_bad,
   output logic [15:0] rx_crc,
   output logic [7:0] rx_lrc
);
   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [15:0] crc_step(input logic [15:0] c);
      return c[0] ? ((c >> 1) ^ `MFCU_CRC_POLY) : (c >> 1);
   endfunction

   function automatic logic [15:0] crc_bytes(input logic [47:0] b);
      logic [15:0] c;
      c = `MFCU_CRC_PRESET;
      for (int i = 0; i < 6; i++) begin
         c = c ^ {8'h00, b[8*i +: 8]};
         for (int j = 0; j < 8; j++) begin
            c = crc_step(c);
         end
      end
      return c;
   endfunction

   function automatic logic [7:0] lrc_bytes(input logic [47:0] b);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 6; i++) begin
         s = s + b[8*i +: 8];
      end
      return 8'h00 - s;
   endfunction

   function automatic logic [4:0] hex_dec(input logic [7:0] ch);
      if (ch >= 8'h30 && ch <= 8'h39) begin
         return {1'b1, ch[3:0]};
      end else if (ch >= 8'h41 && ch <= 8'h46) begin
         return {1'b1, ch[3:0] + 4'h9};
      end
      return 5'h00;
   endfunction

   function automatic logic [7:0] hex_enc(input logic [3:0] n);
      return (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
   endfunction

   function automatic logic [7:0] tx_char(input logic asc, input logic [4:0] idx,
                                          input logic [63:0] rep);
      logic [4:0] k;
      logic [7:0] b;
      k = idx - 5'h01;
      b = rep[{k[3:1], 3'b000} +: 8];
      if (!asc) begin
         return rep[{idx[2:0], 3'b000} +: 8];
      end else if (idx == 5'h00) begin
         return `MFCU_CHR_START;
      end else if (idx == `MFCU_TX_LAST_ASCII - 5'h01) begin
         return `MFCU_CHR_CR;
      end else if (idx == `MFCU_TX_LAST_ASCII) begin
         return `MFCU_CHR_LF;
      end
      return hex_enc(k[0] ? b[3:0] : b[7:4]);
   endfunction

   // ************************************************************
   // receive buffer
   // ************************************************************
   logic f_valid, f_ready, f_last;
   logic [7:0] f_byte;

   mfcu_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) i_mfcu_fifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data({rx_last, rx_data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data({f_last, f_byte})
   );

   // ************************************************************
   // receive checker
   // ************************************************************
   mfcu_pkg::mfcu_rx_st_t rx_st_q, rx_st_d;
   mfcu_pkg::mfcu_tx_st_t tx_st_q, tx_st_d;
   logic [15:0] crc_q, crc_d;
   logic [7:0] lrc_q, lrc_d;
   logic [2:0] step_q, step_d;
   logic [3:0] nib_q, nib_d;
   logic nib_have_q, nib_have_d, cr_q, cr_d, in_frame_q, in_frame_d;
   logic err_q, err_d, last_q, last_d, good_q, good_d, bad_q, bad_d;
   logic [5:0] nbytes_q, nbytes_d;
   logic [47:0] hdr_q, hdr_d;
   logic take, frame_ok, want_reply, tx_start;
   logic [4:0] hx;
   logic [7:0] abyte;

   // the shift state stalls the buffer, so a full buffer back-pressures the link
   assign f_ready = (rx_st_q == mfcu_pkg::RX_COLLECT);
   assign take = f_valid && f_ready;
   assign hx = hex_dec(f_byte);
   assign abyte = {nib_q, hx[3:0]};
   assign frame_ok = mode_ascii
      ? (!err_q && !nib_have_q && lrc_q == 8'h00 && nbytes_q >= `MFCU_MIN_ASCII)
      : (crc_q == 16'h0000 && nbytes_q >= `MFCU_MIN_RTU);
   assign want_reply = hdr_q[15:8] == `MFCU_FUNC_WMULTI && hdr_q[7:0] != `MFCU_ADDR_BCAST
      && nbytes_q >= (mode_ascii ? `MFCU_REQ_MIN_ASCII : `MFCU_REQ_MIN_RTU);
   assign tx_start = (rx_st_q == mfcu_pkg::RX_EVAL) && frame_ok && want_reply;

   always_comb begin
      rx_st_d = rx_st_q;
      crc_d = crc_q;
      lrc_d = lrc_q;
      step_d = step_q;
      nib_d = nib_q;
      nib_have_d = nib_have_q;
      cr_d = cr_q;
      in_frame_d = in_frame_q;
      err_d = err_q;
      last_d = last_q;
      nbytes_d = nbytes_q;
      hdr_d = hdr_q;
      good_d = 1'b0;
      bad_d = 1'b0;
      case (rx_st_q)
         mfcu_pkg::RX_COLLECT: begin
            if (take && mode_ascii) begin
               if (f_byte == `MFCU_CHR_START) begin
                  in_frame_d = 1'b1;
                  lrc_d = 8'h00;
                  nib_have_d = 1'b0;
                  cr_d = 1'b0;
                  err_d = 1'b0;
                  nbytes_d = 6'h00;
               end else if (!in_frame_q) begin
                  in_frame_d = 1'b0;
               end else if (hx[4] && !cr_q) begin
                  nib_d = hx[3:0];
                  nib_have_d = !nib_have_q;
                  if (nib_have_q) begin
                     lrc_d = lrc_q + abyte;
                     if (nbytes_q < `MFCU_HDR_BYTES) begin
                        hdr_d[{nbytes_q[2:0], 3'b000} +: 8] = abyte;
                     end
                     if (nbytes_q != `MFCU_NBYTES_MAX) begin
                        nbytes_d = nbytes_q + 6'h01;
                     end
                  end
               end else if (f_byte == `MFCU_CHR_CR && !cr_q) begin
                  cr_d = 1'b1;
               // lf after cr closes the frame
               end else if (f_byte == `MFCU_CHR_LF && cr_q) begin
                  rx_st_d = mfcu_pkg::RX_EVAL;
               end else begin
                  err_d = 1'b1;
               end
            end else if (take) begin
               crc_d = (in_frame_q ? crc_q : `MFCU_CRC_PRESET) ^ {8'h00, f_byte};
               in_frame_d = 1'b1;
               last_d = f_last;
               step_d = 3'h0;
               if (!in_frame_q) begin
                  nbytes_d = 6'h01;
                  hdr_d[7:0] = f_byte;
               end else begin
                  if (nbytes_q < `MFCU_HDR_BYTES) begin
                     hdr_d[{nbytes_q[2:0], 3'b000} +: 8] = f_byte;
                  end
                  if (nbytes_q != `MFCU_NBYTES_MAX) begin
                     nbytes_d = nbytes_q + 6'h01;
                  end
               end
               rx_st_d = mfcu_pkg::RX_SHIFT;
            end
         end
         mfcu_pkg::RX_SHIFT: begin
            crc_d = crc_step(crc_q);
            step_d = step_q + 3'h1;
            if (step_q == `MFCU_LAST_STEP) begin
               // last byte leaves the final check
               rx_st_d = last_q ? mfcu_pkg::RX_EVAL : mfcu_pkg::RX_COLLECT;
            end
         end
         mfcu_pkg::RX_EVAL: begin
            good_d = frame_ok;
            bad_d = !frame_ok;
            in_frame_d = 1'b0;
            cr_d = 1'b0;
            rx_st_d = tx_start ? mfcu_pkg::RX_WAIT : mfcu_pkg::RX_COLLECT;
         end
         mfcu_pkg::RX_WAIT: begin
            // half duplex: no new request is taken while replying
            if (tx_st_q == mfcu_pkg::TX_IDLE) begin
               rx_st_d = mfcu_pkg::RX_COLLECT;
            end
         end
         default: begin
            rx_st_d = mfcu_pkg::RX_COLLECT;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rx_st_q <= mfcu_pkg::RX_COLLECT;
         crc_q <= `MFCU_CRC_PRESET;
         lrc_q <= 8'h00;
         step_q <= 3'h0;
         nib_q <= 4'h0;
         nib_have_q <= 1'b0;
         cr_q <= 1'b0;
         in_frame_q <= 1'b0;
         err_q <= 1'b0;
         last_q <= 1'b0;
         nbytes_q <= 6'h00;
         hdr_q <= 48'h0;
         good_q <= 1'b0;
         bad_q <= 1'b0;
      end else begin
         rx_st_q <= rx_st_d;
         crc_q <= crc_d;
         lrc_q <= lrc_d;
         step_q <= step_d;
         nib_q <= nib_d;
         nib_have_q <= nib_have_d;
         cr_q <= cr_d;
         in_frame_q <= in_frame_d;
         err_q <= err_d;
         last_q <= last_d;
         nbytes_q <= nbytes_d;
         hdr_q <= hdr_d;
         good_q <= good_d;
         bad_q <= bad_d;
      end
   end

   assign frame_good = good_q;
   assign frame_bad = bad_q;
   assign rx_crc = crc_q;
   assign rx_lrc = lrc_q;

   // ************************************************************
   // reply transmitter
   // ************************************************************
   logic [63:0] rep_q, rep_d;
   logic [4:0] idx_q, idx_d;
   logic [7:0] txd_q, txd_d;
   logic txv_q, txv_d, asc_q, asc_d;
   logic [15:0] rep_crc;
   logic [7:0] rep_lrc;

   assign rep_crc = crc_bytes(hdr_q);
   // negated sum as the check byte
   assign rep_lrc = lrc_bytes(hdr_q);

   always_comb begin
      tx_st_d = tx_st_q;
      rep_d = rep_q;
      idx_d = idx_q;
      txd_d = txd_q;
      txv_d = txv_q;
      asc_d = asc_q;
      case (tx_st_q)
         mfcu_pkg::TX_IDLE: begin
            if (tx_start) begin
               // crc low byte in the earlier slot
               rep_d = {mode_ascii ? {8'h00, rep_lrc} : rep_crc, hdr_q};
               asc_d = mode_ascii;
               idx_d = 5'h00;
               txd_d = tx_char(mode_ascii, 5'h00, rep_d);
               txv_d = 1'b1;
               tx_st_d = mfcu_pkg::TX_SEND;
            end
         end
         mfcu_pkg::TX_SEND: begin
            if (tx_ready) begin
               if (idx_q == (asc_q ? `MFCU_TX_LAST_ASCII : `MFCU_TX_LAST_RTU)) begin
                  txv_d = 1'b0;
                  tx_st_d = mfcu_pkg::TX_IDLE;
               end else begin
                  idx_d = idx_q + 5'h01;
                  txd_d = tx_char(asc_q, idx_d, rep_q);
               end
            end
         end
         default: begin
            tx_st_d = mfcu_pkg::TX_IDLE;
            txv_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tx_st_q <= mfcu_pkg::TX_IDLE;
         rep_q <= 64'h0;
         idx_q <= 5'h00;
         txd_q <= 8'h00;
         txv_q <= 1'b0;
         asc_q <= 1'b0;
      end else begin
         tx_st_q <= tx_st_d;
         rep_q <= rep_d;
         idx_q <= idx_d;
         txd_q <= txd_d;
         txv_q <= txv_d;
         asc_q <= asc_d;
      end
   end

   assign tx_valid = txv_q;
   assign tx_data = txd_q;

   // ************************************************************
   // checks
   // ************************************************************
   a_crc_preset: assert property (@(posedge clk_sys) disable iff (!rstn)
      take && !mode_ascii && !in_frame_q |=> crc_q[15:8] == 8'hff)
      else $error("crc not preset at frame start");
   a_fold_low: assert property (@(posedge clk_sys) disable iff (!rstn)
      take && !mode_ascii && in_frame_q
      |=> crc_q == ($past(crc_q) ^ {8'h00, $past(f_byte)}))
      else $error("byte not folded into low half");
   a_shift_step: assert property (@(posedge clk_sys) disable iff (!rstn)
      rx_st_q == mfcu_pkg::RX_SHIFT && crc_q[0]
      |=> crc_q[15] && crc_q[13] == !$past(crc_q[14]))
      else $error("polynomial not applied");
   a_eight_steps: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(rx_st_q == mfcu_pkg::RX_SHIFT)
      |-> (rx_st_q == mfcu_pkg::RX_SHIFT)[*8] ##1 rx_st_q != mfcu_pkg::RX_SHIFT)
      else $error("byte not given eight steps");
   a_lrc_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
      take && mode_ascii && hx[4] && nib_have_q && in_frame_q && !cr_q
      |=> lrc_q == 8'($past(lrc_q) + $past(abyte)))
      else $error("sum not wrapped to eight bits");
   a_bad_silent: assert property (@(posedge clk_sys) disable iff (!rstn)
      rx_st_q == mfcu_pkg::RX_EVAL && !frame_ok |=> !tx_valid [*3])
      else $error("reply to a bad frame");
   a_reply_start: assert property (@(posedge clk_sys) disable iff (!rstn)
      tx_start |=> tx_valid && tx_data == (mode_ascii ? `MFCU_CHR_START : hdr_q[7:0]))
      else $error("reply did not start");
   a_crc_low_first: assert property (@(posedge clk_sys) disable iff (!rstn)
      tx_valid && !asc_q && idx_q == 5'h06 |-> tx_data == rep_q[55:48])
      else $error("crc high byte sent first");
   a_lrc_negate: assert property (@(posedge clk_sys) disable iff (!rstn)
      tx_valid && asc_q |-> 8'(rep_q[7:0] + rep_q[15:8] + rep_q[23:16] + rep_q[31:24]
      + rep_q[39:32] + rep_q[47:40] + rep_q[55:48]) == 8'h00)
      else $error("check byte is not the negated sum");
   a_ascii_tail: assert property (@(posedge clk_sys) disable iff (!rstn)
      tx_valid && asc_q && idx_q == `MFCU_TX_LAST_ASCII |-> tx_data == `MFCU_CHR_LF
      && ($past(tx_data) == `MFCU_CHR_CR || $past(idx_q) == idx_q))
      else $error("ascii reply tail wrong");
endmodule
`default_nettype wire

// ---- test/mfcu_master_model.sv ----
// Purpose: serial master stand-in, feeds requests and takes replies
// Assumes: one clock; drives 1 ns after the rising edge
// Notes: slow mode drops tx_ready every other cycle
`default_nettype none
module mfcu_master_model (
   // clock
   input wire logic clk_sys,
   // request side
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic rx_last,
   // reply side
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] replyq[$];
   logic slow;

   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_last = 1'b0;
      tx_ready = 1'b1;
      slow = 1'b0;
   end

   // ************
   // request side
   // ************
   // every byte held until taken
   task automatic send_frame(input logic [7:0] q[$], input logic rtu);
      for (int i = 0; i < q.size(); i++) begin
         rx_valid = 1'b1;
         rx_data = q[i];
         rx_last = rtu && (i == q.size() - 1);
         while (rx_ready !== 1'b1) begin
            @(posedge clk_sys);
            #1;
         end
         @(posedge clk_sys);
         #1;
      end
      rx_valid = 1'b0;
      // released line shows the inverse, never a stale byte
      rx_data = ~rx_data;
      rx_last = 1'b0;
   endtask

   // ************
   // reply side
   // ************
   always @(posedge clk_sys) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         replyq.push_back(tx_data);
      end
      #1;
      tx_ready = slow ? ~tx_ready : 1'b1;
   end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: self-checking bench of the frame check unit
// Assumes: expectations built here from the check rules
// Notes: each task runs one or two scenarios
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   typedef logic [7:0] mfcu_bq_t[$];
   logic clk_sys;
   logic rstn;
   logic mode_ascii;
   logic rx_valid;
   logic rx_ready;
   logic [7:0] rx_data;
   logic rx_last;
   logic tx_valid;
   logic tx_ready;
   logic [7:0] tx_data;
   logic frame_good;
   logic frame_bad;
   logic [15:0] rx_crc;
   logic [7:0] rx_lrc;
   int error_cnt = 0;
   int total_checks = 0;
   int good_cnt = 0;
   int bad_cnt = 0;
   int cycles = 0;

   mfcu_frame_check #(.FIFO_DEPTH(8)) i_mfcu_frame_check (.clk_sys(clk_sys), .rstn(rstn),
      .mode_ascii(mode_ascii), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .rx_last(rx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .frame_good(frame_good), .frame_bad(frame_bad), .rx_crc(rx_crc), .rx_lrc(rx_lrc));
   mfcu_master_model i_mfcu_master_model (.clk_sys(clk_sys), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data));

   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cycles++;
      if (frame_good === 1'b1) good_cnt++;
      if (frame_bad === 1'b1) bad_cnt++;
      // whole run needs about 800 cycles
      if (cycles == 6000) begin
         error_cnt++;
         $display("wrong value timeout expected done seen hang");
         end_of_test();
      end
   end

   // ************
   // helpers
   // ************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   function automatic logic [15:0] crc16(input mfcu_bq_t q);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction

   function automatic mfcu_bq_t add_crc(input mfcu_bq_t q);
      logic [15:0] c;
      c = crc16(q);
      return {q, c[7:0], c[15:8]};
   endfunction

   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction

   // ascii frame with negated byte sum
   function automatic mfcu_bq_t to_ascii(input mfcu_bq_t q);
      mfcu_bq_t r;
      logic [7:0] s;
      r = {8'h3a};
      s = 8'h00;
      foreach (q[i]) begin
         s = s + q[i];
         r = {r, hexc(q[i][7:4]), hexc(q[i][3:0])};
      end
      s = -s;
      return {r, hexc(s[7:4]), hexc(s[3:0]), 8'h0d, 8'h0a};
   endfunction

   // sends one request, then judges verdict and whole reply
   task automatic run_frame(input string name, input logic asc, input mfcu_bq_t req,
         input logic good, input mfcu_bq_t rep);
      int g0;
      int b0;
      int n;
      g0 = good_cnt;
      b0 = bad_cnt;
      n = 0;
      mode_ascii = asc;
      i_mfcu_master_model.replyq.delete();
      i_mfcu_master_model.send_frame(req, !asc);
      while (i_mfcu_master_model.replyq.size() < rep.size() || good_cnt + bad_cnt == g0 + b0)
      begin
         if (n == 600) break;
         @(posedge clk_sys);
         #1;
         n++;
      end
      // quiet spell, so a stray reply would show
      repeat (40) @(posedge clk_sys);
      #1;
      check("frame_good", 16'(good_cnt - g0), {15'h0000, good});
      check("frame_bad", 16'(bad_cnt - b0), {15'h0000, !good});
      check("reply_len", 16'(i_mfcu_master_model.replyq.size()), 16'(rep.size()));
      foreach (rep[i]) begin
         if (i < i_mfcu_master_model.replyq.size()) begin
            check("reply_byte", {8'h00, i_mfcu_master_model.replyq[i]}, {8'h00, rep[i]});
         end
      end
      $display("test %s done", name);
   endtask

   // ************
   // scenarios
   // ************
   task automatic t_rtu_good();
      mfcu_bq_t hdr;
      hdr = {8'h01, 8'h10, 8'h05, 8'h00, 8'h00, 8'h02};
      i_mfcu_master_model.slow = 1'b1;
      // two registers from 0500h, reply stalled
      run_frame("rtu_good", 1'b0, add_crc({hdr, 8'h04, 8'h13, 8'h88, 8'h0f, 8'ha0}), 1'b1,
         add_crc(hdr));
      i_mfcu_master_model.slow = 1'b0;
      check("crc_low", {8'h00, i_mfcu_master_model.replyq[6]}, 16'h0041);
      check("crc_high", {8'h00, i_mfcu_master_model.replyq[7]}, 16'h0004);
      check("rx_crc", rx_crc, 16'h0000);
   endtask

   task automatic t_rtu_bad();
      mfcu_bq_t req;
      req = add_crc({8'h01, 8'h10, 8'h05, 8'h00, 8'h00, 8'h02, 8'h04, 8'h13, 8'h88, 8'h0f,
         8'ha0});
      req[req.size() - 1] = req[req.size() - 1] ^ 8'h01;
      run_frame("rtu_bad", 1'b0, req, 1'b0, '{});
   endtask

   task automatic t_rtu_silent();
      run_frame("rtu_bcast", 1'b0, add_crc({8'h00, 8'h10, 8'h05, 8'h00, 8'h00, 8'h01, 8'h02,
         8'h13, 8'h88}), 1'b1, '{});
      // fixed check bytes; a read is good but unanswered
      run_frame("rtu_read", 1'b0, {8'h01, 8'h03, 8'h21, 8'h02, 8'h00, 8'h02, 8'h6f, 8'hf7},
         1'b1, '{});
   endtask

   task automatic t_ascii_good();
      mfcu_bq_t hdr;
      hdr = {8'h01, 8'h10, 8'h05, 8'h00, 8'h00, 8'h02};
      run_frame("ascii_good", 1'b1, to_ascii({hdr, 8'h04, 8'h13, 8'h88, 8'h0f, 8'ha0}), 1'b1,
         to_ascii(hdr));
      check("lrc_hi_char", {8'h00, i_mfcu_master_model.replyq[13]}, 16'h0045);
      check("lrc_lo_char", {8'h00, i_mfcu_master_model.replyq[14]}, 16'h0038);
      check("end_cr", {8'h00, i_mfcu_master_model.replyq[15]}, 16'h000d);
      check("end_lf", {8'h00, i_mfcu_master_model.replyq[16]}, 16'h000a);
      check("rx_lrc", {8'h00, rx_lrc}, 16'h0000);
   endtask

   task automatic t_ascii_bad();
      mfcu_bq_t req;
      // sum wraps past 256 in this read request
      run_frame("ascii_read", 1'b1, to_ascii({8'h01, 8'h03, 8'h04, 8'h01, 8'h00, 8'h01,
         8'hff, 8'h80}), 1'b1, '{});
      req = to_ascii({8'h01, 8'h10, 8'h05, 8'h00, 8'h00, 8'h02, 8'h04, 8'h13, 8'h88, 8'h0f,
         8'ha0});
      req[req.size() - 3] = 8'h42;
      run_frame("ascii_bad", 1'b1, req, 1'b0, '{});
   endtask

   initial begin
      rstn = 1'b0;
      mode_ascii = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      rstn = 1'b1;
      t_rtu_good();
      t_rtu_bad();
      t_rtu_silent();
      t_ascii_good();
      t_ascii_bad();
      end_of_test();
   end
endmodule
`default_nettype wire
